// ===== verilog/ubgt_top.v
// Purpose: Clock prescaler, fractional baud generator and serial transmitter with FIFO.
// Assumes: i_mclk is the oscillator clock; register port inputs are synchronous to it.
// Notes: Register accesses take one clock and never wait on the sampling tick.
`include "ubgt_consts.vh"
`default_nettype none

// Overview of operation
// - Each channel owns its baud generator, clocked from the oscillator input clock.
// - Register accesses finish without waiting on the baud clock.
// - Modem control bit 7 selects prescaler divide by one or by four.
// - Prescale select pin sets the default prescaler after reset; software may override.
// - Divisor is programmable from one to under 65536 in sixteenth steps.
// - Reset loads low byte one, high byte zero, fraction zero.
// - Low and high bytes form integer divisor; fraction register gives fractional part.
// - Low four fraction bits select zero to fifteen sixteenths.
// - Effective divisor is high times 256 plus low plus fraction over sixteen.
// - Fraction register bits 5:4 select 16X, 8X or 4X sampling.
// - Data rate equals clock over prescaler over divisor times sampling factor.
// - Odd fractions in 8X mode may jitter bit times by one sixteenth.
// - Shifter advances one bit per 16, 8 or 4 sampling ticks.
// - Frame is start bit, data bits, optional parity, then stop bits.
// - Bit 0 of each written byte goes out first after start.
// - Transmit holding register is write only and eight bits wide.
// - With FIFO enabled, holding register writes enter a 32 byte FIFO.
// - Each holding register write that finds room (count below capacity) advances the FIFO write pointer.
// - Line status bit 5 shows holding or FIFO empty, bit 6 holding/FIFO and shifter both empty.
module ubgt_top #(
	parameter DEPTH = `UBGT_FIFO_DEPTH,
	parameter AW = `UBGT_FIFO_AW
) (
	input wire i_mclk,
	input wire i_rst_b,
	input wire i_ce,
	input wire i_prescale_select_pin,
	input wire [2:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_wdata,
	output wire [7:0] o_rdata,
	output wire o_tx,
	output wire o_samp_tick
);

	localparam S_IDLE = 5'b00001;
	localparam S_START = 5'b00010;
	localparam S_DATA = 5'b00100;
	localparam S_PAR = 5'b01000;
	localparam S_STOP = 5'b10000;

	function [4:0] ubgt_spb;
		input [1:0] mode;
		begin
			case (mode)
				`UBGT_MODE_8X: ubgt_spb = 5'h08;
				`UBGT_MODE_4X: ubgt_spb = 5'h04;
				default: ubgt_spb = 5'h10;
			endcase
		end
	endfunction

	reg rst_meta_q;
	reg rst_sync_q;
	wire rst_n = rst_sync_q;

	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	reg [7:0] div_lo_q;
	reg [7:0] div_hi_q;
	reg [7:0] div_frac_q;
	reg [7:0] lcr_q;
	reg [7:0] modem_ctl_q;
	reg [7:0] fifo_ctl_q;
	reg strap_done_q;
	reg [7:0] rdata_q;

	wire dlab = lcr_q[`UBGT_LCR_DLAB_BIT];
	wire fifo_en = fifo_ctl_q[`UBGT_FIFOCTL_EN_BIT];
	wire wr_hold = i_wr && (i_addr == `UBGT_ADDR_HOLD) && !dlab;
	wire wr_fifo_ctl = i_wr && (i_addr == `UBGT_ADDR_FIFOCTL) && !dlab;
	wire div_wr = i_wr && dlab && ((i_addr == `UBGT_ADDR_HOLD) || (i_addr == `UBGT_ADDR_DIVHI) ||
		(i_addr == `UBGT_ADDR_FIFOCTL));

	localparam [AW:0] CAP_FIFO = DEPTH;
	reg [7:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] cnt_q;
	reg [4:0] state_q;
	wire [AW:0] cap = fifo_en ? CAP_FIFO : {{AW{1'b0}}, 1'b1};
	wire push = wr_hold && (cnt_q < cap);
	wire pop = (state_q == S_IDLE) && (cnt_q != {(AW+1){1'b0}});
	wire fifo_clr = wr_fifo_ctl && (i_wdata[`UBGT_FIFOCTL_TXCLR_BIT] || (i_wdata[`UBGT_FIFOCTL_EN_BIT] != fifo_en));
	wire hold_empty = (cnt_q == {(AW+1){1'b0}});
	wire tx_empty = hold_empty && (state_q == S_IDLE);

	// Registers live on i_mclk with single-cycle access, independent of the sampling tick
	always @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_lo_q <= `UBGT_DIVLO_RST;
			div_hi_q <= `UBGT_DIVHI_RST;
			div_frac_q <= `UBGT_DIVFRAC_RST;
			lcr_q <= `UBGT_LCR_RST;
			modem_ctl_q <= `UBGT_MODEMCTL_RST;
			fifo_ctl_q <= `UBGT_FIFOCTL_RST;
			strap_done_q <= 1'b0;
			rdata_q <= 8'h00;
		end else if (i_ce) begin
			// Strap is caught on the first enabled clock after reset release
			if (!strap_done_q) begin
				strap_done_q <= 1'b1;
				modem_ctl_q[`UBGT_MODEMCTL_PRESC_BIT] <= i_prescale_select_pin;
			end
			if (i_wr) begin
				case (i_addr)
					`UBGT_ADDR_HOLD: begin
						if (dlab) begin
							div_lo_q <= i_wdata;
						end
					end
					`UBGT_ADDR_DIVHI: begin
						if (dlab) begin
							div_hi_q <= i_wdata;
						end
					end
					`UBGT_ADDR_FIFOCTL: begin
						if (dlab) begin
							div_frac_q <= i_wdata & (`UBGT_DIVFRAC_FRAC_MASK | `UBGT_DIVFRAC_MODE_MASK);
						end else begin
							fifo_ctl_q <= {7'h00, i_wdata[`UBGT_FIFOCTL_EN_BIT]};
						end
					end
					`UBGT_ADDR_LCR: lcr_q <= i_wdata;
					`UBGT_ADDR_MODEMCTL: modem_ctl_q <= i_wdata;
					default: begin
					end
				endcase
			end
			if (i_rd) begin
				case (i_addr)
					`UBGT_ADDR_HOLD: rdata_q <= dlab ? div_lo_q : 8'h00;
					`UBGT_ADDR_DIVHI: rdata_q <= dlab ? div_hi_q : 8'h00;
					`UBGT_ADDR_FIFOCTL: rdata_q <= dlab ? div_frac_q : 8'h00;
					`UBGT_ADDR_LCR: rdata_q <= lcr_q;
					`UBGT_ADDR_MODEMCTL: rdata_q <= modem_ctl_q;
					`UBGT_ADDR_LINESTAT: rdata_q <= {1'b0, tx_empty, hold_empty, 5'h00};
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	// Prescaler: every clock, or every fourth clock
	reg [1:0] pre_cnt_q;
	wire div4 = modem_ctl_q[`UBGT_MODEMCTL_PRESC_BIT];
	wire pre_tick = !div4 || (pre_cnt_q == `UBGT_PRESC_DIV4_LAST);

	// Fractional divider in sixteenths; a zero integer part is treated as one
	wire [15:0] div_int = {div_hi_q, div_lo_q};
	wire [15:0] div_int_eff = (div_int == 16'h0000) ? 16'h0001 : div_int;
	wire [19:0] div16 = {div_int_eff, div_frac_q[3:0]};
	reg [19:0] acc_q;
	wire [20:0] acc_sum = {1'b0, acc_q} + 21'h000010;
	wire samp_hit = pre_tick && (acc_sum >= {1'b0, div16});
	reg samp_tick_q;

	always @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_q <= 2'h0;
			acc_q <= 20'h00000;
			samp_tick_q <= 1'b0;
		end else if (i_ce) begin
			pre_cnt_q <= div4 ? pre_cnt_q + 2'h1 : 2'h0;
			samp_tick_q <= samp_hit;
			// Uneven tick spacing from the fraction is the documented jitter, not an error
			// A new divisor restarts the count, else a shrunk divisor drains the old remainder as a tick burst
			if (div_wr) begin
				acc_q <= 20'h00000;
			end else if (pre_tick) begin
				if (samp_hit) begin
					acc_q <= acc_sum[19:0] - div16;
				end else begin
					acc_q <= acc_sum[19:0];
				end
			end
		end
	end

	assign o_samp_tick = samp_tick_q;

	// Transmit FIFO; capacity one when FIFO mode is off
	always @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (i_ce) begin
			if (fifo_clr) begin
				wr_ptr_q <= {AW{1'b0}};
				rd_ptr_q <= {AW{1'b0}};
				cnt_q <= {(AW+1){1'b0}};
			end else begin
				if (push) begin
					wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
				end
				if (pop) begin
					rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
				end
				if (push && !pop) begin
					cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
				end else if (pop && !push) begin
					cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
				end
			end
		end
	end

	// Memory has no reset; only written slots are ever read
	always @(posedge i_mclk) begin
		if (i_ce && push && !fifo_clr) begin
			mem[wr_ptr_q] <= i_wdata;
		end
	end

	// Serial framing
	reg [7:0] sh_q;
	reg [4:0] samp_cnt_q;
	reg [2:0] bit_cnt_q;
	reg stop_cnt_q;
	reg par_q;
	reg tx_q;
	wire [4:0] spb = ubgt_spb(div_frac_q[5:4]);
	wire bit_end = samp_tick_q && (samp_cnt_q >= spb - 5'h01);
	wire [2:0] last_bit = {1'b1, lcr_q[1:0]};
	wire [7:0] pop_data = mem[rd_ptr_q];
	wire [7:0] wl_mask = 8'hFF >> (2'h3 - lcr_q[1:0]);
	wire pen = lcr_q[`UBGT_LCR_PEN_BIT];
	wire even = lcr_q[`UBGT_LCR_EVEN_BIT];
	wire par_calc = lcr_q[`UBGT_LCR_STICK_BIT] ? !even : ((^(pop_data & wl_mask)) ^ !even);

	always @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			sh_q <= 8'h00;
			samp_cnt_q <= 5'h00;
			bit_cnt_q <= 3'h0;
			stop_cnt_q <= 1'b0;
			par_q <= 1'b0;
			tx_q <= 1'b1;
		end else if (i_ce) begin
			if (samp_tick_q) begin
				samp_cnt_q <= bit_end ? 5'h00 : samp_cnt_q + 5'h01;
			end
			case (state_q)
				S_IDLE: begin
					tx_q <= 1'b1;
					if (pop) begin
						sh_q <= pop_data;
						par_q <= par_calc;
						samp_cnt_q <= 5'h00;
						tx_q <= 1'b0;
						state_q <= S_START;
					end
				end
				S_START: begin
					if (bit_end) begin
						tx_q <= sh_q[0];
						bit_cnt_q <= 3'h0;
						state_q <= S_DATA;
					end
				end
				S_DATA: begin
					if (bit_end) begin
						if (bit_cnt_q == last_bit) begin
							tx_q <= pen ? par_q : 1'b1;
							stop_cnt_q <= lcr_q[`UBGT_LCR_STOP_BIT];
							state_q <= pen ? S_PAR : S_STOP;
						end else begin
							tx_q <= sh_q[1];
							sh_q <= {1'b0, sh_q[7:1]};
							bit_cnt_q <= bit_cnt_q + 3'h1;
						end
					end
				end
				S_PAR: begin
					if (bit_end) begin
						tx_q <= 1'b1;
						state_q <= S_STOP;
					end
				end
				S_STOP: begin
					if (bit_end) begin
						if (stop_cnt_q) begin
							stop_cnt_q <= 1'b0;
						end else begin
							state_q <= S_IDLE;
						end
					end
				end
				default: begin
					state_q <= S_IDLE;
					tx_q <= 1'b1;
				end
			endcase
		end
	end

	assign o_tx = tx_q;
	assign o_rdata = rdata_q;

endmodule // ubgt_top

`default_nettype wire

// ===== include/ubgt_consts.vh
// Purpose: Constants for the baud generator and transmitter block.
// Assumes: Eight-bit register port with three address lines.
// Notes: Offsets, field positions, reset values and counts.
`ifndef UBGT_CONSTS_VH
`define UBGT_CONSTS_VH

`define UBGT_ADDR_HOLD 3'h0
`define UBGT_ADDR_DIVHI 3'h1
`define UBGT_ADDR_FIFOCTL 3'h2
`define UBGT_ADDR_LCR 3'h3
`define UBGT_ADDR_MODEMCTL 3'h4
`define UBGT_ADDR_LINESTAT 3'h5

`define UBGT_DIVLO_RST 8'h01
`define UBGT_DIVHI_RST 8'h00
`define UBGT_DIVFRAC_RST 8'h00
`define UBGT_LCR_RST 8'h00
`define UBGT_MODEMCTL_RST 8'h00
`define UBGT_FIFOCTL_RST 8'h00

`define UBGT_LCR_DLAB_BIT 7
`define UBGT_LCR_STOP_BIT 2
`define UBGT_LCR_PEN_BIT 3
`define UBGT_LCR_EVEN_BIT 4
`define UBGT_LCR_STICK_BIT 5
`define UBGT_MODEMCTL_PRESC_BIT 7
`define UBGT_FIFOCTL_EN_BIT 0
`define UBGT_FIFOCTL_TXCLR_BIT 2
`define UBGT_LINESTAT_HOLDEMPTY_BIT 5
`define UBGT_LINESTAT_SHEMPTY_BIT 6

`define UBGT_DIVFRAC_FRAC_MASK 8'h0F
`define UBGT_DIVFRAC_MODE_MASK 8'h30
`define UBGT_MODE_16X 2'h0
`define UBGT_MODE_8X 2'h1
`define UBGT_MODE_4X 2'h2

`define UBGT_PRESC_DIV4_LAST 2'h3
`define UBGT_FIFO_DEPTH 32
`define UBGT_FIFO_AW 5

`endif

// ===== test/ubgt_props.sv
// Purpose: Port assertions for ubgt_top
// Assumes: One clock domain
// Notes: Tracks divisor access from writes
`include "ubgt_consts.vh"
`default_nettype none
module ubgt_props (
	input wire i_mclk,
	input wire i_rst_b,
	input wire i_ce,
	input wire i_prescale_select_pin,
	input wire [2:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_wdata,
	input wire [7:0] o_rdata,
	input wire o_tx,
	input wire o_samp_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic dlab_q;
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b)
			dlab_q <= 1'b0;
		else if (i_ce && i_wr && i_addr == `UBGT_ADDR_LCR)
			dlab_q <= i_wdata[`UBGT_LCR_DLAB_BIT];
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	sequence s_rd_stat;
		i_ce && i_rd && i_addr == `UBGT_ADDR_LINESTAT;
	endsequence
	sequence s_start;
		!o_tx [*3];
	endsequence
	a_rdata_hold: assert property (!(i_ce && i_rd) |=> $stable(o_rdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (i_ce && i_rd && i_addr > 3'h5 |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_hold_wonly: assert property (i_ce && i_rd && i_addr == `UBGT_ADDR_HOLD && !dlab_q |=> o_rdata == 8'h00)
		else $error("holding register readable");
	a_high_hidden: assert property (i_ce && i_rd && i_addr == `UBGT_ADDR_DIVHI && !dlab_q |=> o_rdata == 8'h00)
		else $error("high divisor visible");
	a_stat_layout: assert property (s_rd_stat |=> (o_rdata & 8'h9F) == 8'h00 && (!o_rdata[6] || o_rdata[5]))
		else $error("status layout wrong");
	a_temt_idle: assert property (s_rd_stat ##1 o_rdata[6] |-> $past(o_tx))
		else $error("empty while line busy");
	a_start_len: assert property ($fell(o_tx) |-> s_start)
		else $error("start bit too short");
	a_ce_freeze: assert property (!i_ce |=> $stable(o_tx) && $stable(o_samp_tick))
		else $error("moved while disabled");
endmodule // ubgt_props
bind ubgt_top ubgt_props u_props (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce),
	.i_prescale_select_pin(i_prescale_select_pin), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
	.i_wdata(i_wdata), .o_rdata(o_rdata), .o_tx(o_tx), .o_samp_tick(o_samp_tick));
`default_nettype wire

// ===== test/ubgt_rx_model.sv
// Purpose: Remote serial receiver
// Assumes: Bit time given in clocks
// Notes: Samples on falling clock edges to avoid races
`default_nettype none
module ubgt_rx_model (
	input wire logic i_mclk,
	input wire logic i_tx,
	input wire logic [15:0] i_bit_cyc,
	input wire logic [3:0] i_nbits,
	input wire logic i_par_en,
	output logic [7:0] o_byte,
	output logic o_bad,
	output logic [7:0] o_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_byte = 8'h00;
		o_bad = 1'b0;
		o_cnt = 8'h00;
		forever begin
			@(negedge i_tx);
			repeat (i_bit_cyc / 2) @(negedge i_mclk);
			if (i_tx !== 1'b0) o_bad = 1'b1;
			o_byte = 8'h00;
			for (int i = 0; i < i_nbits; i++) begin
				repeat (i_bit_cyc) @(negedge i_mclk);
				o_byte[i] = i_tx;
			end
			if (i_par_en) begin
				repeat (i_bit_cyc) @(negedge i_mclk);
				if (i_tx !== ^o_byte) o_bad = 1'b1;
			end
			repeat (i_bit_cyc) @(negedge i_mclk);
			if (i_tx !== 1'b1) o_bad = 1'b1;
			o_cnt = o_cnt + 8'h01;
		end
	end
endmodule // ubgt_rx_model
`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench for ubgt_top
// Assumes: Register port driven on rising edges
// Notes: Bit timing judged by the serial model
`include "ubgt_consts.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk, i_rst_b, i_ce, i_prescale_select_pin, i_wr, i_rd, o_tx, o_samp_tick, rx_bad, par_en;
	logic [2:0] i_addr;
	logic [7:0] i_wdata, o_rdata, rx_byte, rx_cnt;
	logic [15:0] bit_cyc;
	logic [3:0] nbits;
	int error_cnt = 0;
	int n_compared = 0;
	ubgt_top u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_prescale_select_pin(i_prescale_select_pin),
		.i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_tx(o_tx),
		.o_samp_tick(o_samp_tick));
	ubgt_rx_model u_rx (.i_mclk(i_mclk), .i_tx(o_tx), .i_bit_cyc(bit_cyc), .i_nbits(nbits), .i_par_en(par_en),
		.o_byte(rx_byte), .o_bad(rx_bad), .o_cnt(rx_cnt));
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		chk({8'h00, o_rdata}, {8'h00, exp});
	endtask
	// Skip two edges so a just-written rate has reached the registered tick
	task automatic ticks(input int n, output int c);
		c = 0;
		repeat (2) @(posedge i_mclk);
		repeat (n) begin
			@(negedge i_mclk);
			if (o_samp_tick === 1'b1) c++;
		end
	endtask
	task automatic frame(input logic [7:0] exp);
		logic [7:0] c0;
		int k;
		c0 = rx_cnt;
		k = 0;
		while (rx_cnt === c0 && k < 2000) begin
			@(negedge i_mclk);
			k++;
		end
		chk(16'(rx_cnt !== c0), 16'd1);
		chk({8'h00, rx_byte}, {8'h00, exp});
		chk({15'h0000, rx_bad}, 16'h0000);
	endtask
	task automatic t_reset;
		int c;
		ticks(40, c);
		chk(16'(c), 16'd10);
		rd(`UBGT_ADDR_MODEMCTL, 8'h80);
		wr(`UBGT_ADDR_MODEMCTL, 8'h00);
		ticks(20, c);
		chk(16'(c), 16'd20);
		wr(`UBGT_ADDR_LCR, 8'h80);
		rd(`UBGT_ADDR_HOLD, `UBGT_DIVLO_RST);
		rd(`UBGT_ADDR_DIVHI, `UBGT_DIVHI_RST);
		rd(`UBGT_ADDR_FIFOCTL, `UBGT_DIVFRAC_RST);
		wr(`UBGT_ADDR_DIVHI, 8'h12);
		rd(`UBGT_ADDR_DIVHI, 8'h12);
		wr(`UBGT_ADDR_LCR, 8'h00);
		rd(`UBGT_ADDR_DIVHI, 8'h00);
		rd(`UBGT_ADDR_HOLD, 8'h00);
		rd(`UBGT_ADDR_LINESTAT, 8'h60);
		rd(3'h6, 8'h00);
		@(posedge i_mclk);
		i_ce <= 1'b0;
		repeat (3) @(posedge i_mclk);
		i_ce <= 1'b1;
		$display("t_reset done");
	endtask
	task automatic t_rate;
		int c;
		wr(`UBGT_ADDR_LCR, 8'h80);
		wr(`UBGT_ADDR_DIVHI, 8'h00);
		wr(`UBGT_ADDR_HOLD, 8'h02);
		wr(`UBGT_ADDR_FIFOCTL, 8'h18);
		ticks(100, c);
		chk(16'(c >= 39 && c <= 41), 16'd1);
		wr(`UBGT_ADDR_LCR, 8'h03);
		wr(`UBGT_ADDR_FIFOCTL, 8'h01);
		wr(`UBGT_ADDR_HOLD, 8'hA5);
		frame(8'hA5);
		$display("t_rate done");
	endtask
	task automatic t_fifo;
		wr(`UBGT_ADDR_LCR, 8'h80);
		wr(`UBGT_ADDR_HOLD, 8'h01);
		wr(`UBGT_ADDR_FIFOCTL, 8'h20);
		wr(`UBGT_ADDR_LCR, 8'h1B);
		bit_cyc = 16'd4;
		par_en = 1'b1;
		wr(`UBGT_ADDR_HOLD, 8'h3C);
		wr(`UBGT_ADDR_HOLD, 8'hC3);
		wr(`UBGT_ADDR_HOLD, 8'h81);
		rd(`UBGT_ADDR_LINESTAT, 8'h00);
		frame(8'h3C);
		frame(8'hC3);
		frame(8'h81);
		repeat (8) @(posedge i_mclk);
		rd(`UBGT_ADDR_LINESTAT, 8'h60);
		$display("t_fifo done");
	endtask
	// Holding register alone, 16X, seven bits, parity and two stops; a third byte must be refused
	task automatic t_plain;
		logic [7:0] c0;
		wr(`UBGT_ADDR_LCR, 8'h80);
		wr(`UBGT_ADDR_HOLD, 8'h01);
		wr(`UBGT_ADDR_FIFOCTL, 8'h00);
		wr(`UBGT_ADDR_LCR, 8'h1E);
		wr(`UBGT_ADDR_FIFOCTL, 8'h00);
		bit_cyc = 16'd16;
		nbits = 4'd7;
		wr(`UBGT_ADDR_HOLD, 8'h55);
		wr(`UBGT_ADDR_HOLD, 8'h2A);
		wr(`UBGT_ADDR_HOLD, 8'h7F);
		rd(`UBGT_ADDR_LINESTAT, 8'h00);
		frame(8'h55);
		frame(8'h2A);
		c0 = rx_cnt;
		repeat (240) @(posedge i_mclk);
		chk({8'h00, rx_cnt}, {8'h00, c0});
		rd(`UBGT_ADDR_LINESTAT, 8'h60);
		$display("t_plain done");
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		i_rst_b = 1'b0;
		i_ce = 1'b1;
		i_prescale_select_pin = 1'b1;
		i_addr = 3'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_wdata = 8'h00;
		bit_cyc = 16'd20;
		nbits = 4'd8;
		par_en = 1'b0;
		repeat (16) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_mclk);
		i_prescale_select_pin <= 1'b0;
		t_reset;
		t_rate;
		t_fifo;
		t_plain;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge i_mclk);
		error_cnt++;
		test_done;
	end
endmodule // tb
`default_nettype wire
